/* File: rtl/scp_device.sv */
// device end of the serial command port with its register bank
`timescale 1ns/10ps
`default_nettype none
`include "scp_regs.svh"
module scp_device
	import scp_pkg::*;
#(
	parameter int NUM_REGS = 9,
	parameter int TIMEOUT_BITS = `SCP_TIMEOUT_BITS
) (
	input wire logic clk, // 200 MHz master clock
	input wire logic srst, // synchronous reset
	input wire logic ce, // clock enable
	scp_if.device link, // serial link
	input wire logic reset_powerdown_pin, // low holds device in reset
	output logic [NUM_REGS*8-1:0] regs_out, // register bank contents
	output logic in_reset // device held in reset
);
	initial begin
		if (NUM_REGS < 1 || NUM_REGS > 16 || TIMEOUT_BITS < 2) begin
			$error("scp_device: bad parameters");
		end
	end

	typedef struct packed {
		logic [2:0] sclk_hist;
		logic [1:0] hold_cnt;
		logic in_reset;
		scp_dev_state_e state;
		logic [2:0] bit_cnt;
		logic [7:0] shift_in;
		logic [7:0] shift_out;
		logic [4:0] ptr;
		logic [3:0] count;
		logic [TIMEOUT_BITS-1:0] idle_cnt;
		logic dout;
		logic dout_oe_n;
		logic [NUM_REGS*8-1:0] regs;
	} scp_dev_s;

	scp_dev_s st_reg;
	scp_dev_s st_next;
	logic [3:0] pins_sync;
	logic rst_pin_s;
	logic cs_n_s;
	logic sclk_s;
	logic din_s;
	logic [7:0] rd_byte;
	logic [7:0] rx_byte;
	logic rise;
	logic fall;
	logic port_reset;

	// pins cross into the master clock domain, reset pin included
	scp_sync #(.WIDTH(4)) u_sync (
		.clk(clk),
		.ce(ce),
		.d({link.cs_n, link.sclk, link.din, reset_powerdown_pin}),
		.q(pins_sync)
	);
	assign {cs_n_s, sclk_s, din_s, rst_pin_s} = pins_sync;

	function automatic logic [NUM_REGS*8-1:0] dflt_regs();
		logic [NUM_REGS*8-1:0] r;
		r = '0;
		for (int i = 0; i < NUM_REGS; i++) begin
			r[i*8 +: 8] = `SCP_DFLT_OTHER;
		end
		r[7:0] = `SCP_DFLT_R0;
		if (NUM_REGS > 3) begin
			r[31:24] = `SCP_DFLT_R3;
		end
		return r;
	endfunction : dflt_regs

	// register read mux, zero beyond the bank
	always_comb begin
		rd_byte = 8'h00;
		for (int i = 0; i < NUM_REGS; i++) begin
			if (st_reg.ptr == 5'(i)) begin
				rd_byte = st_reg.regs[i*8 +: 8];
			end
		end
	end

	assign rise = st_reg.sclk_hist[1] & ~st_reg.sclk_hist[2];
	assign fall = ~st_reg.sclk_hist[1] & st_reg.sclk_hist[2];
	assign rx_byte = {st_reg.shift_in[6:0], din_s};
	assign port_reset = cs_n_s | st_reg.in_reset
		| (&st_reg.idle_cnt & ~st_reg.sclk_hist[1]);

	// one next-state process for the whole end
	always_comb begin
		st_next = st_reg;
		st_next.sclk_hist = {st_reg.sclk_hist[1:0], sclk_s};
		// timeout only counts while clock sits low
		if (st_reg.sclk_hist[1]) begin
			st_next.idle_cnt = '0;
		end else begin
			st_next.idle_cnt = st_reg.idle_cnt + 1'b1;
		end
		// enable follows select; tied-low select keeps dout driven
		st_next.dout_oe_n = cs_n_s;
		// reset pin low holds, then one more cycle
		if (!rst_pin_s) begin
			st_next.in_reset = 1'b1;
			st_next.hold_cnt = `SCP_RST_HOLD;
			st_next.regs = dflt_regs();
		end else if (st_reg.hold_cnt != 2'h0) begin
			st_next.hold_cnt = st_reg.hold_cnt - 2'h1;
			st_next.in_reset = (st_reg.hold_cnt != 2'h1);
		end
		if (port_reset) begin
			st_next.state = SCP_CMD1;
			st_next.bit_cnt = 3'h0;
			st_next.dout = 1'b0;
		end else if (rise) begin
			st_next.shift_in = rx_byte;
			st_next.bit_cnt = st_reg.bit_cnt + 3'h1;
			if (st_reg.bit_cnt == `SCP_BIT_LAST) begin
				case (st_reg.state)
					SCP_CMD1: begin
						if (rx_byte[7:4] == `SCP_OP_READ) begin
							st_next.state = SCP_CMD2;
							st_next.count = 4'h0;
							st_next.ptr = {1'b0, rx_byte[3:0]};
						end else if (rx_byte[7:4] == `SCP_OP_WRITE) begin
							st_next.state = SCP_CMD2;
							st_next.count = 4'h1;
							st_next.ptr = {1'b0, rx_byte[3:0]};
						end else if (rx_byte[7:1] == `SCP_OP_RESET) begin
							st_next.regs = dflt_regs();
						end
						// other bytes fall through here
					end
					SCP_CMD2: begin
						st_next.state = st_reg.count[0] ? SCP_WDATA : SCP_RDATA;
						st_next.count = rx_byte[3:0];
					end
					SCP_WDATA: begin
						for (int i = 0; i < NUM_REGS; i++) begin
							if (st_reg.ptr == 5'(i)) begin
								st_next.regs[i*8 +: 8] = rx_byte;
							end
						end
						if (st_reg.ptr != 5'h1f) begin
							st_next.ptr = st_reg.ptr + 5'h1;
						end
						st_next.count = st_reg.count - 4'h1;
						st_next.state = (st_reg.count == 4'h0) ? SCP_CMD1 : SCP_WDATA;
					end
					SCP_RDATA: begin
						st_next.count = st_reg.count - 4'h1;
						st_next.state = (st_reg.count == 4'h0) ? SCP_CMD1 : SCP_RDATA;
					end
					default: begin
						st_next.state = SCP_CMD1;
					end
				endcase
			end
		end else if (fall) begin
			// output shifts on falling edges in read data only
			if (st_reg.state == SCP_RDATA) begin
				if (st_reg.bit_cnt == 3'h0) begin
					st_next.dout = rd_byte[7];
					st_next.shift_out = {rd_byte[6:0], 1'b0};
					if (st_reg.ptr != 5'h1f) begin
						st_next.ptr = st_reg.ptr + 5'h1;
					end
				end else begin
					st_next.dout = st_reg.shift_out[7];
					st_next.shift_out = {st_reg.shift_out[6:0], 1'b0};
				end
			end
		end
	end

	// state register, frozen while ce low
	always_ff @(posedge clk) begin
		if (srst) begin
			st_reg <= '{
				sclk_hist: 3'h0,
				hold_cnt: `SCP_RST_HOLD,
				in_reset: 1'b1,
				state: SCP_CMD1,
				bit_cnt: 3'h0,
				shift_in: 8'h00,
				shift_out: 8'h00,
				ptr: 5'h00,
				count: 4'h0,
				idle_cnt: '0,
				dout: 1'b0,
				dout_oe_n: 1'b1,
				regs: dflt_regs()
			};
		end else if (ce) begin
			st_reg <= st_next;
		end
	end

	assign link.dout = st_reg.dout;
	assign link.dout_oe_n = st_reg.dout_oe_n;
	assign regs_out = st_reg.regs;
	assign in_reset = st_reg.in_reset;
endmodule : scp_device
`default_nettype wire

/* File: rtl/scp_regs.svh */
// constants for the serial command port
`ifndef SCP_REGS_SVH
`define SCP_REGS_SVH
`define SCP_OP_READ 4'h2
`define SCP_OP_WRITE 4'h4
`define SCP_OP_RESET 7'h03
`define SCP_TIMEOUT_BITS 18
`define SCP_RST_HOLD 2'h2
`define SCP_NUM_REGS 5'h09
`define SCP_DFLT_R0 8'h18
`define SCP_DFLT_R3 8'h07
`define SCP_DFLT_OTHER 8'h00
`define SCP_BIT_LAST 3'h7
`define SCP_HOST_DIV 4'h6
`endif

/* File: rtl/scp_pkg.sv */
// types shared by both ends of the serial command port
`default_nettype none
package scp_pkg;
	typedef enum logic [2:0] {
		SCP_CMD1,
		SCP_CMD2,
		SCP_RDATA,
		SCP_WDATA,
		SCP_SKIP
	} scp_dev_state_e;
	typedef enum logic [2:0] {
		SCP_H_IDLE,
		SCP_H_LOW,
		SCP_H_HIGH,
		SCP_H_DONE
	} scp_host_state_e;
endpackage : scp_pkg
`default_nettype wire

/* File: rtl/scp_if.sv */
// four-wire link between host and device
`timescale 1ns/10ps
`default_nettype none
interface scp_if;
	logic cs_n; // chip select, low active
	logic sclk; // serial clock from host
	logic din; // host to device data
	logic dout; // device data out level
	logic dout_oe_n; // low while device drives dout
	modport device (input cs_n, input sclk, input din, output dout, output dout_oe_n);
	modport host (output cs_n, output sclk, output din, input dout, input dout_oe_n);
endinterface : scp_if
`default_nettype wire

/* File: rtl/scp_sync.sv */
// two-stage synchroniser for pin inputs
`timescale 1ns/10ps
`default_nettype none
module scp_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk, // system clock
	input wire logic ce, // clock enable
	input wire logic [WIDTH-1:0] d, // asynchronous inputs
	output logic [WIDTH-1:0] q // synchronised outputs
);
	logic [WIDTH-1:0] meta_reg;
	// first stage feeds only the second
	always_ff @(posedge clk) begin
		if (ce) begin
			meta_reg <= d;
			q <= meta_reg;
		end
	end
endmodule : scp_sync
`default_nettype wire

/* File: rtl/scp_host.sv */
// host end: runs one command byte-framed transfer
`timescale 1ns/10ps
`default_nettype none
`include "scp_regs.svh"
module scp_host
	import scp_pkg::*;
#(
	parameter int MAX_BYTES = 18
) (
	input wire logic clk, // system clock
	input wire logic srst, // synchronous reset
	input wire logic ce, // clock enable
	scp_if.host link, // serial link
	input wire logic start, // pulse: begin transfer
	input wire logic [4:0] nbytes, // bytes in transfer, 1..MAX_BYTES
	input wire logic [MAX_BYTES*8-1:0] tx_data, // byte 0 in low bits
	output logic busy, // transfer in progress
	output logic done, // pulse: transfer finished
	output logic [MAX_BYTES*8-1:0] rx_data // dout bytes captured
);
	initial begin
		if (MAX_BYTES < 2 || MAX_BYTES > 31) begin
			$error("scp_host: bad MAX_BYTES");
		end
	end

	typedef struct packed {
		scp_host_state_e state;
		logic [3:0] div;
		logic [2:0] bit_cnt;
		logic [4:0] byte_idx;
		logic [4:0] nbytes;
		logic [MAX_BYTES*8-1:0] tx;
		logic [MAX_BYTES*8-1:0] rx;
		logic cs_n;
		logic sclk;
		logic din;
		logic busy;
		logic done;
	} scp_host_s;

	scp_host_s st_reg;
	scp_host_s st_next;
	logic dout_s;

	// device data is asynchronous to us
	scp_sync #(.WIDTH(1)) u_sync (
		.clk(clk),
		.ce(ce),
		.d(link.dout),
		.q(dout_s)
	);

	// divider makes the serial clock; capture with sync delay margin
	always_comb begin
		st_next = st_reg;
		st_next.done = 1'b0;
		st_next.div = st_reg.div + 4'h1;
		case (st_reg.state)
			SCP_H_IDLE: begin
				st_next.div = 4'h0;
				// first rise comes one half period after select, so a timeout loses no bit
				if (start && nbytes != 5'h0) begin
					st_next.state = SCP_H_LOW;
					st_next.cs_n = 1'b0;
					st_next.busy = 1'b1;
					st_next.nbytes = nbytes;
					st_next.tx = tx_data;
					st_next.rx = '0;
					st_next.bit_cnt = 3'h0;
					st_next.byte_idx = 5'h0;
					st_next.din = tx_data[7];
				end
			end
			SCP_H_LOW: begin
				if (st_reg.div == `SCP_HOST_DIV) begin
					st_next.div = 4'h0;
					st_next.sclk = 1'b1;
					st_next.state = SCP_H_HIGH;
				end
			end
			SCP_H_HIGH: begin
				if (st_reg.div == `SCP_HOST_DIV) begin
					st_next.div = 4'h0;
					st_next.sclk = 1'b0;
					// dout settled since previous falling edge
					for (int i = 0; i < MAX_BYTES; i++) begin
						if (st_reg.byte_idx == 5'(i)) begin
							st_next.rx[i*8 + 7 - st_reg.bit_cnt] = dout_s;
						end
					end
					st_next.bit_cnt = st_reg.bit_cnt + 3'h1;
					if (st_reg.bit_cnt == `SCP_BIT_LAST) begin
						st_next.byte_idx = st_reg.byte_idx + 5'h1;
					end
					if (st_reg.bit_cnt == `SCP_BIT_LAST
						&& st_reg.byte_idx + 5'h1 == st_reg.nbytes) begin
						st_next.state = SCP_H_DONE;
						st_next.din = 1'b0;
					end else begin
						st_next.state = SCP_H_LOW;
						st_next.din = st_reg.tx[{st_next.byte_idx, 3'h7 - st_next.bit_cnt}];
					end
				end
			end
			SCP_H_DONE: begin
				if (st_reg.div == `SCP_HOST_DIV) begin
					st_next.cs_n = 1'b1;
					st_next.busy = 1'b0;
					st_next.done = 1'b1;
					st_next.state = SCP_H_IDLE;
				end
			end
			default: begin
				st_next.state = SCP_H_IDLE;
			end
		endcase
	end

	// state register, frozen while ce low
	always_ff @(posedge clk) begin
		if (srst) begin
			st_reg <= '0;
			st_reg.state <= SCP_H_IDLE;
			st_reg.cs_n <= 1'b1;
		end else if (ce) begin
			st_reg <= st_next;
		end
	end

	assign link.cs_n = st_reg.cs_n;
	assign link.sclk = st_reg.sclk;
	assign link.din = st_reg.din;
	assign busy = st_reg.busy;
	assign done = st_reg.done;
	assign rx_data = st_reg.rx;
endmodule : scp_host
`default_nettype wire

/* File: test/scp_link_monitor.sv */
// checker on the link between host and device
`timescale 1ns/10ps
`default_nettype none
module scp_link_monitor (
	input wire logic clk, // system clock
	input wire logic srst, // sync reset
	input wire logic cs_n, // chip select
	input wire logic sclk, // serial clock
	input wire logic din, // host data
	input wire logic dout, // device data
	input wire logic dout_oe_n // low when driven
);
	logic sclk_reg; // sclk one cycle back
	logic [7:0] fall_reg; // recent sclk falls
	logic [2:0] cnt_reg; // rises this frame
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	// edge history; select high restarts the bit count
	always_ff @(posedge clk) begin
		sclk_reg <= sclk;
		if (srst) begin
			fall_reg <= 8'h00;
			cnt_reg <= 3'h0;
		end else begin
			fall_reg <= {fall_reg[6:0], sclk_reg & ~sclk};
			if (cs_n) begin
				cnt_reg <= 3'h0;
			end else if (sclk & ~sclk_reg) begin
				cnt_reg <= cnt_reg + 3'h1;
			end
		end
	end
	a_oe_off_unsel: assert property (cs_n [*5] |-> dout_oe_n && !dout)
		else $error("dout live while idle");
	a_oe_on_sel: assert property (!cs_n [*5] |-> !dout_oe_n)
		else $error("dout not driven");
	a_dout_after_fall: assert property ($changed(dout) && !cs_n |-> |fall_reg[7:1])
		else $error("dout moved off a fall");
	a_din_low_change: assert property ($changed(din) |-> !sclk)
		else $error("din moved, sclk high");
	a_high_half_min: assert property ($rose(sclk) |=> sclk [*5])
		else $error("short high half");
	a_low_half_min: assert property ($fell(sclk) |=> !sclk [*5])
		else $error("short low half");
	a_cs_sclk_low: assert property ($changed(cs_n) |-> !sclk && !$past(sclk))
		else $error("select moved mid bit");
	a_byte_frame: assert property ($rose(cs_n) |-> cnt_reg == 3'h0)
		else $error("frame not whole bytes");
	c_frame: cover property ($rose(cs_n));
	c_read_one: cover property (!dout_oe_n && dout);
	c_select: cover property ($fell(dout_oe_n));
endmodule : scp_link_monitor
`default_nettype wire

/* File: test/test_serial_command_port.sv */
// bench for the serial command port
`timescale 1ns/10ps
`default_nettype none
module test_serial_command_port;
	localparam int NB = 18;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic reset_powerdown_pin = 1'b1;
	logic start = 1'b0;
	logic [4:0] nbytes = 5'h00;
	logic [NB*8-1:0] tx_data = '0;
	logic busy, done, in_reset;
	logic [NB*8-1:0] rx;
	logic [71:0] regs, regs2;
	logic [7:0] model [9];
	int failures = 0;
	int tests_run = 0;
	scp_if lk ();
	scp_if lk2 ();
	scp_host #(.MAX_BYTES(NB)) scp_host_i (.clk(clk), .srst(srst), .ce(1'b1),
		.link(lk.host), .start(start), .nbytes(nbytes), .tx_data(tx_data),
		.busy(busy), .done(done), .rx_data(rx));
	scp_device #(.TIMEOUT_BITS(6)) scp_device_i (.clk(clk), .srst(srst), .ce(1'b1),
		.link(lk.device), .reset_powerdown_pin(reset_powerdown_pin),
		.regs_out(regs), .in_reset(in_reset));
	// second device, bit-banged by the bench with select held low through the timeout test
	scp_device #(.TIMEOUT_BITS(6)) scp_device_f_i (.clk(clk), .srst(srst), .ce(1'b1),
		.link(lk2.device), .reset_powerdown_pin(reset_powerdown_pin),
		.regs_out(regs2), .in_reset());
	scp_link_monitor scp_link_monitor_i (.clk(clk), .srst(srst), .cs_n(lk.cs_n),
		.sclk(lk.sclk), .din(lk.din), .dout(lk.dout), .dout_oe_n(lk.dout_oe_n));
	// 200 MHz clock
	always #2.5 clk = ~clk;
	task automatic print_verdict;
		$display("compares %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : print_verdict
	task automatic check(input string m, input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask : check
	task automatic dflt;
		foreach (model[k]) model[k] = 8'h00;
		model[0] = 8'h18;
		model[3] = 8'h07;
	endtask : dflt
	task automatic check_regs;
		for (int k = 0; k < 9; k++) check("reg", regs[8*k+:8], model[k]);
	endtask : check_regs
	// one host transfer, bounded wait on done
	task automatic run(input logic [4:0] n, input logic [NB*8-1:0] d);
		int k;
		nbytes = n;
		tx_data = d;
		start = 1'b1;
		@(posedge clk);
		#1 start = 1'b0;
		check("busy", {7'h0, busy}, 8'h01);
		k = 0;
		while (done !== 1'b1 && k < 3000) begin
			@(negedge clk);
			k++;
		end
		if (k >= 3000) check("done", 8'h00, 8'h01);
		check("idle", {7'h0, busy}, 8'h00);
		@(posedge clk);
		#1 check("pulse", {7'h0, done}, 8'h00);
	endtask : run
	task automatic rd(input logic [3:0] a, input logic [3:0] c);
		logic [NB*8-1:0] d;
		d = '0;
		d[15:0] = {4'h0, c, 4'h2, a};
		run(5'(c) + 5'h3, d);
		check("rd cmd", rx[7:0] | rx[15:8], 8'h00);
		for (int k = 0; k <= c; k++) check("rd", rx[8*k+16+:8], (a + k < 9) ? model[a+k] : 8'h00);
	endtask : rd
	task automatic wr(input logic [3:0] a, input logic [3:0] c, input logic [NB*8-1:0] e);
		run(5'(c) + 5'h3, {e[NB*8-17:0], 4'h0, c, 4'h4, a});
		check("wr dout", {7'h0, |rx}, 8'h00);
		for (int k = 0; k <= c; k++) if (a + k < 9) model[a+k] = e[8*k+:8];
		check_regs();
	endtask : wr
	// raw bits on the second link, msb first
	task automatic bb(input logic [7:0] b, input int n);
		for (int i = 7; i > 7 - n; i--) begin
			lk2.din = b[i];
			repeat (7) @(posedge clk);
			#1 lk2.sclk = 1'b1;
			repeat (7) @(posedge clk);
			#1 lk2.sclk = 1'b0;
		end
	endtask : bb
	task automatic t_read;
		check_regs();
		rd(4'h0, 4'h9);
		rd(4'he, 4'h3);
		$display("read test done");
	endtask : t_read
	task automatic t_write;
		wr(4'h7, 4'h2, 24'h993ca5);
		rd(4'h6, 4'h3);
		$display("write test done");
	endtask : t_write
	task automatic t_cmds;
		for (int k = 6; k < 8; k++) begin
			wr(4'h1, 4'h0, 8'h5a);
			run(5'h1, 8'(k));
			dflt();
			check_regs();
		end
		wr(4'h1, 4'h0, 8'h5a);
		run(5'h1, 8'h05);
		run(5'h1, 8'h08);
		run(5'h1, 8'h30);
		check_regs();
		$display("command test done");
	endtask : t_cmds
	task automatic t_pin;
		wr(4'h2, 4'h0, 8'h81);
		reset_powerdown_pin = 1'b0;
		repeat (3) @(posedge clk);
		#1 reset_powerdown_pin = 1'b1;
		@(posedge clk);
		#1 check("held", {7'h0, in_reset}, 8'h01);
		repeat (4) @(posedge clk);
		#1 check("freed", {7'h0, in_reset}, 8'h00);
		dflt();
		check_regs();
		$display("pin reset test done");
	endtask : t_pin
	// half byte then idle low must realign; idle high must not
	task automatic t_timeout;
		lk2.cs_n = 1'b0;
		bb(8'h41, 4);
		// resume before a second interval can elapse
		repeat (80) @(posedge clk);
		#1 bb(8'h41, 8);
		bb(8'h00, 8);
		bb(8'hc3, 8);
		check("timeout", regs2[15:8], 8'hc3);
		check("tied", {7'h0, lk2.dout_oe_n}, 8'h00);
		// half byte whose last high half is held through the idle
		bb(8'h41, 3);
		lk2.din = 1'b0;
		repeat (7) @(posedge clk);
		#1 lk2.sclk = 1'b1;
		repeat (80) @(posedge clk);
		#1 lk2.sclk = 1'b0;
		bb(8'h41, 8);
		bb(8'h00, 8);
		bb(8'h3c, 8);
		check("idle high", regs2[15:8], 8'hc3);
		lk2.cs_n = 1'b1;
		repeat (8) @(posedge clk);
		#1 check("released", {7'h0, lk2.dout_oe_n}, 8'h01);
		$display("timeout test done");
	endtask : t_timeout
	// main sequence
	initial begin
		lk2.cs_n = 1'b1;
		lk2.sclk = 1'b0;
		lk2.din = 1'b0;
		dflt();
		repeat (2) @(posedge clk);
		#1 srst = 1'b0;
		repeat (4) @(posedge clk);
		#1 t_read();
		t_write();
		t_cmds();
		t_pin();
		t_timeout();
		print_verdict();
	end
	// watchdog well beyond the expected run
	initial begin
		#300000;
		failures++;
		$display("MISMATCH %0t watchdog expired", $time);
		print_verdict();
	end
endmodule : test_serial_command_port
`default_nettype wire
